// ---- tws_pkg.sv ----
/*
  Shared constants and carrier types for the two-wire bus buffer with
  stuck-bus recovery. Assumes a 40 MHz reference clock; link timing is
  counted in link-clock cycles.
*/
package tws_pkg;
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  localparam int unsigned STUCK_TIMEOUT_MS = 30;
  localparam int unsigned STUCK_CYC = STUCK_TIMEOUT_MS * (REF_CLK_HZ / 1000);
  localparam int unsigned BUS_IDLE_US = 95;
  localparam int unsigned IDLE_CYC = BUS_IDLE_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned RECOV_HALF_US = 5;
  localparam int unsigned RECOV_HALF_CYC =
    RECOV_HALF_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned RECOV_PULSES = 16;
  localparam int unsigned LINK_HOLD_CYC = 32;
  localparam int unsigned STUCK_W = 21;
  localparam int unsigned IDLE_W = 12;
  localparam int unsigned HALF_W = 8;
  localparam int unsigned PULSE_W = 5;
  localparam int unsigned HOLD_W = 6;
  localparam logic RST_READY_OE = 1'b1;
  localparam logic RST_LINE_OE = 1'b0;
  localparam logic DRIVE_LEVEL = 1'b0;

  typedef struct packed {
    logic bp_data;
    logic bp_clock;
    logic card_data;
    logic card_clock;
  } tws_lines_type;

  typedef struct packed {
    logic connect;
    logic recov_low;
  } tws_ctl_type;

  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT, ST_CONN, ST_RECOV, ST_STUCK_WAIT
  } tws_state_type;

  typedef enum logic [1:0] {
    OWN_NONE, OWN_BP, OWN_CARD, OWN_HOLD
  } tws_own_type;
endpackage

// ---- tws_sync.sv ----
/*
  Two-flip-flop level synchroniser, WIDTH bits wide.
  Assumes each bit is a level that is stable for several destination cycles.
*/
`timescale 1ns/1ps
module tws_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds the second stage only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ---- tws_buffer.sv ----
/*
  Connection and stuck-bus recovery control for a two-wire bus buffer.
  Assumes external pull-ups on all lines and a wired-AND resolver in the
  bench; the link domain runs on its own clock with its own reset.
*/
`timescale 1ns/1ps
// What this block does
// - While joined, a low on either side is copied to the other side.
// - A card data or clock low held for 30 ms with no card line rise breaks the connection.
// - A stuck break drives at most 16 pulses on the card clock.
// - After a stuck break, the join returns once the card bus is free.
// - With enable high, the first join comes only after a backplane stop or bus idle.
// - Enable low opens both data and clock paths at once.
// - The open-drain ready output is released only while joined.
module tws_buffer #(
  parameter int unsigned STUCK_CYCLES = tws_pkg::STUCK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_link_srst,
  input wire logic i_enable,
  input wire logic i_backplane_data_line,
  output logic o_backplane_data_line,
  output logic o_backplane_data_line_oe,
  input wire logic i_backplane_clock_line,
  output logic o_backplane_clock_line,
  output logic o_backplane_clock_line_oe,
  input wire logic i_card_data_line,
  output logic o_card_data_line,
  output logic o_card_data_line_oe,
  input wire logic i_card_clock_line,
  output logic o_card_clock_line,
  output logic o_card_clock_line_oe,
  output logic o_ready,
  output logic o_ready_oe
);
  import tws_pkg::*;

  tws_lines_type pins, lk_ln, rf_ln, rf_prev_q;
  tws_ctl_type ctl_q, lk_ctl;
  logic en_s, lk_low_q, phase_high_q;
  logic [1:0] bp_low, card_low, bp_oe_q, card_oe_q;
  tws_own_type own_q [2];
  logic [HOLD_W-1:0] hold_q [2];
  tws_state_type state_q;
  logic [STUCK_W-1:0] stuck_cnt_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic [HALF_W-1:0] half_cnt_q;
  logic [PULSE_W-1:0] pulse_cnt_q;
  logic stuck_low, card_rise, card_free, stop_det;
  logic idle_done, stuck_done, half_done;

  assign pins = '{bp_data: i_backplane_data_line,
                  bp_clock: i_backplane_clock_line,
                  card_data: i_card_data_line,
                  card_clock: i_card_clock_line};

  // Link-domain view of the pins and of the control word
  tws_sync #(.WIDTH(4)) u_lk_pins (
    .i_clk(i_link_clk),
    .i_srst(i_link_srst),
    .i_async(pins),
    .o_sync(lk_ln)
  );
  tws_sync #(.WIDTH(2)) u_lk_ctl (
    .i_clk(i_link_clk),
    .i_srst(i_link_srst),
    .i_async(ctl_q),
    .o_sync(lk_ctl)
  );
  // Reference-domain view of the pins and the enable
  tws_sync #(.WIDTH(5)) u_rf_pins (
    .i_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async({i_enable, pins}),
    .o_sync({en_s, rf_ln})
  );

  assign bp_low = {~lk_ln.bp_clock, ~lk_ln.bp_data};
  assign card_low = {~lk_ln.card_clock, ~lk_ln.card_data};
  // Direction ownership per line. The hold phase masks our own echo while
  // the released line rises; a side driven low again inside it is missed.
  always_ff @(posedge i_link_clk) begin
    if (i_link_srst) begin
      for (int i = 0; i < 2; i++) begin
        own_q[i] <= OWN_NONE;
        hold_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        case (own_q[i])
          OWN_NONE: begin
            hold_q[i] <= '0;
            if (lk_ctl.connect && bp_low[i]) begin
              own_q[i] <= OWN_BP;
            end else if (lk_ctl.connect && card_low[i]) begin
              own_q[i] <= OWN_CARD;
            end
          end
          OWN_BP: begin
            if (!lk_ctl.connect || !bp_low[i]) begin
              own_q[i] <= OWN_HOLD;
            end
          end
          OWN_CARD: begin
            if (!lk_ctl.connect || !card_low[i]) begin
              own_q[i] <= OWN_HOLD;
            end
          end
          OWN_HOLD: begin
            if (hold_q[i] == HOLD_W'(LINK_HOLD_CYC - 1)) begin
              own_q[i] <= OWN_NONE;
            end else begin
              hold_q[i] <= hold_q[i] + 1'b1;
            end
          end
          default: own_q[i] <= OWN_NONE;
        endcase
      end
    end
  end

  // Drive enables, gated by connect so a drop opens both paths at once
  always_ff @(posedge i_link_clk) begin
    if (i_link_srst) begin
      bp_oe_q <= {2{RST_LINE_OE}};
      card_oe_q <= {2{RST_LINE_OE}};
      lk_low_q <= DRIVE_LEVEL;
    end else begin
      lk_low_q <= DRIVE_LEVEL;
      for (int i = 0; i < 2; i++) begin
        bp_oe_q[i] <= lk_ctl.connect && own_q[i] == OWN_CARD;
      end
      card_oe_q[0] <= lk_ctl.connect && own_q[0] == OWN_BP;
      card_oe_q[1] <= (lk_ctl.connect && own_q[1] == OWN_BP) ||
                      lk_ctl.recov_low;
    end
  end

  assign {o_backplane_data_line, o_backplane_clock_line} = {2{lk_low_q}};
  assign {o_card_data_line, o_card_clock_line} = {2{lk_low_q}};
  assign {o_backplane_clock_line_oe, o_backplane_data_line_oe} = bp_oe_q;
  assign {o_card_clock_line_oe, o_card_data_line_oe} = card_oe_q;

  // Reference-domain event decode
  assign stuck_low = !rf_ln.card_data || !rf_ln.card_clock;
  assign card_rise = (rf_ln.card_data && !rf_prev_q.card_data) ||
                     (rf_ln.card_clock && !rf_prev_q.card_clock);
  assign card_free = rf_ln.card_data && rf_ln.card_clock;
  assign stop_det = rf_ln.bp_data && !rf_prev_q.bp_data &&
                    rf_ln.bp_clock && rf_prev_q.bp_clock;
  assign idle_done = idle_cnt_q == IDLE_W'(IDLE_CYC - 1);
  assign stuck_done = stuck_cnt_q == STUCK_W'(STUCK_CYCLES - 1);
  assign half_done = half_cnt_q == HALF_W'(RECOV_HALF_CYC - 1);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rf_prev_q <= '1;
    end else begin
      rf_prev_q <= rf_ln;
    end
  end
  // Stuck-low timer, restarted whenever a card line rises
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      stuck_cnt_q <= '0;
    end else if (state_q != ST_CONN || !stuck_low || card_rise) begin
      stuck_cnt_q <= '0;
    end else if (!stuck_done) begin
      stuck_cnt_q <= stuck_cnt_q + 1'b1;
    end
  end

  // Backplane idle timer
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      idle_cnt_q <= '0;
    end else if (!rf_ln.bp_data || !rf_ln.bp_clock || state_q != ST_WAIT) begin
      idle_cnt_q <= '0;
    end else if (!idle_done) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= ST_OFF;
    end else if (!en_s) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (stop_det || idle_done) begin
            state_q <= ST_CONN;
          end
        end
        ST_CONN: begin
          if (stuck_low && stuck_done && !card_rise) begin
            state_q <= ST_RECOV;
          end
        end
        ST_RECOV: begin
          if (phase_high_q && card_free) begin
            state_q <= ST_STUCK_WAIT;
          end else if (phase_high_q && half_done &&
                       pulse_cnt_q == PULSE_W'(RECOV_PULSES - 1)) begin
            state_q <= ST_STUCK_WAIT;
          end
        end
        ST_STUCK_WAIT: begin
          if (card_free) begin
            state_q <= ST_CONN;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Recovery pulse timing: low half first, then released half
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_q != ST_RECOV) begin
      half_cnt_q <= '0;
      pulse_cnt_q <= '0;
      phase_high_q <= 1'b0;
    end else if (half_done) begin
      half_cnt_q <= '0;
      phase_high_q <= !phase_high_q;
      if (phase_high_q) begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end
    end else begin
      half_cnt_q <= half_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctl_q <= '0;
      o_ready <= DRIVE_LEVEL;
      o_ready_oe <= RST_READY_OE;
    end else begin
      ctl_q.connect <= en_s && state_q == ST_CONN;
      ctl_q.recov_low <= en_s && state_q == ST_RECOV && !phase_high_q;
      o_ready <= DRIVE_LEVEL;
      o_ready_oe <= !(en_s && state_q == ST_CONN);
    end
  end
  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_pass_to_card: assert property (@(posedge i_link_clk)
      disable iff (i_link_srst)
      (lk_ctl.connect && own_q[g] == OWN_BP) |=> card_oe_q[g])
      else $error("backplane low not copied to card");
    a_pass_to_bp: assert property (@(posedge i_link_clk)
      disable iff (i_link_srst)
      (lk_ctl.connect && own_q[g] == OWN_CARD) |=> bp_oe_q[g])
      else $error("card low not copied to backplane");
  end

  a_stuck_break: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    (en_s && state_q == ST_CONN && stuck_low && stuck_done && !card_rise)
    |=> state_q == ST_RECOV ##1 !ctl_q.connect)
    else $error("stuck bus did not break the connection");
  a_pulse_limit: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    pulse_cnt_q <= PULSE_W'(RECOV_PULSES))
    else $error("too many recovery pulses");
  a_stuck_resume: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    (en_s && state_q == ST_STUCK_WAIT && card_free) |=> state_q == ST_CONN)
    else $error("connection not restored after stuck bus cleared");
  a_connect_cause: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    (state_q == ST_WAIT && !stop_det && !idle_done) |=> state_q != ST_CONN)
    else $error("joined without stop or idle");
  a_enable_off: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    !en_s |=> (state_q == ST_OFF && !ctl_q.connect && o_ready_oe))
    else $error("enable low did not open the paths");
  a_ready_track: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    o_ready_oe != ctl_q.connect)
    else $error("ready not released while joined");
  a_early_stop: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    (en_s && state_q == ST_RECOV && phase_high_q && card_free)
    |=> state_q == ST_STUCK_WAIT ##1 state_q != ST_RECOV)
    else $error("recovery did not stop on free card bus");
  a_timer_restart: assert property (@(posedge i_ref_clk)
    disable iff (i_srst)
    card_rise |=> stuck_cnt_q == '0)
    else $error("stuck timer not restarted on card line rise");
endmodule

// ---- tws_partner.sv ----
/*
  Far-side model: pull-ups and wired-AND on all four lines, plus a card
  that can hold its data line low until it has seen a set number of
  card clock falls. Assumes the bench supplies the other parties' pulls.
*/
`timescale 1ns/1ps
module tws_partner (
  input wire logic [3:0] i_pull,
  input wire logic [3:0] i_oe,
  input wire logic i_card_stuck,
  input wire logic [4:0] i_release_after,
  output tws_pkg::tws_lines_type o_lines,
  output logic [4:0] o_falls
);
  import tws_pkg::*;
  logic hold;
  initial o_falls = 5'h00;
  // A stuck card lets go only after enough recovery clocks
  assign hold = i_card_stuck && (o_falls < i_release_after);
  // Released lines float to the pull-up level
  assign o_lines = ~(i_pull | i_oe | {2'b00, hold, 1'b0});
  // Clock is high when a stuck episode starts, so that edge clears
  always @(negedge o_lines.card_clock or posedge i_card_stuck) begin
    if (o_lines.card_clock) o_falls <= 5'h00;
    else o_falls <= o_falls + 5'h01;
  end
endmodule

// ---- tws_buffer_bench.sv ----
/*
  Self-checking bench for the two-wire buffer control block.
  Assumes a shortened stuck timeout and the partner model on the lines.
*/
`timescale 1ns/1ps
module tws_buffer_bench;
  import tws_pkg::*;
  localparam int unsigned STK = 2000;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic enable = 1'b0;
  logic [3:0] pull = 4'h0;
  logic stuck = 1'b0;
  logic [4:0] rel = 5'h03;
  logic [3:0] oe;
  logic [3:0] lvl;
  logic [3:0] drv;
  logic [4:0] falls;
  logic ready_oe;
  logic ready_lvl;
  logic ready_low;
  tws_lines_type w;
  logic [3:0] wv;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  assign wv = w;
  // A pin is pulled low only where the block drives a low level
  assign drv = oe & ~lvl;
  assign ready_low = ready_oe && !ready_lvl;
  always #12.5 ref_clk = ~ref_clk;
  // Edges of the two clocks coincide every 150 ns at these periods
  always #6 link_clk = ~link_clk;
  tws_buffer #(.STUCK_CYCLES(STK)) tws_buffer_inst (
    .i_ref_clk(ref_clk), .i_srst(srst),
    .i_link_clk(link_clk), .i_link_srst(srst), .i_enable(enable),
    .i_backplane_data_line(w.bp_data), .o_backplane_data_line(lvl[3]),
    .o_backplane_data_line_oe(oe[3]),
    .i_backplane_clock_line(w.bp_clock), .o_backplane_clock_line(lvl[2]),
    .o_backplane_clock_line_oe(oe[2]),
    .i_card_data_line(w.card_data), .o_card_data_line(lvl[1]),
    .o_card_data_line_oe(oe[1]),
    .i_card_clock_line(w.card_clock), .o_card_clock_line(lvl[0]),
    .o_card_clock_line_oe(oe[0]),
    .o_ready(ready_lvl), .o_ready_oe(ready_oe)
  );
  tws_partner tws_partner_inst (
    .i_pull(pull), .i_oe(drv), .i_card_stuck(stuck),
    .i_release_after(rel), .o_lines(w), .o_falls(falls)
  );
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // Counts cycles until ready reaches the level; a spent bound ends the run
  task automatic wait_rdy(input logic exp, input int bound, output int c);
    c = 0;
    while (ready_low !== exp) begin
      @(posedge ref_clk);
      #1;
      c++;
      if (c > bound) begin
        err_count++;
        summarize();
      end
    end
  endtask
  task automatic s_idle();
    tick(1);
    enable <= 1'b1;
    wait_rdy(1'b0, 7200, n);
    chk(n >= 2200 && n <= 7000, 1'b1);
  endtask
  task automatic s_pass();
    for (int i = 0; i < 4; i++) begin
      tick(1);
      pull[i] <= 1'b1;
      tick(10);
      #1;
      chk(wv[i ^ 2], 1'b0);
      tick(1);
      pull[i] <= 1'b0;
      tick(30);
      #1;
      chk(wv[i ^ 2], 1'b1);
    end
  endtask
  task automatic s_enoff();
    tick(1);
    pull[3] <= 1'b1;
    tick(10);
    enable <= 1'b0;
    wait_rdy(1'b1, 6, n);
    tick(5);
    #1;
    chk(w.card_data, 1'b1);
    tick(1);
    pull <= 4'h4;
    tick(10);
    #1;
    chk(w.card_clock, 1'b1);
    tick(1);
    pull <= 4'h0;
    tick(40);
  endtask
  task automatic s_stop();
    tick(1);
    enable <= 1'b1;
    tick(20);
    pull[3] <= 1'b1;
    tick(20);
    pull[3] <= 1'b0;
    // Far below the idle interval, so only the stop can join
    wait_rdy(1'b0, 100, n);
  endtask
  // Card clock stays low past the timeout; only the data rise restarts it
  task automatic s_restart();
    tick(1);
    pull[0] <= 1'b1;
    tick(1500);
    pull[1] <= 1'b1;
    tick(40);
    pull[1] <= 1'b0;
    tick(1500);
    #1;
    chk(ready_low, 1'b0);
    tick(1);
    pull[0] <= 1'b0;
    tick(40);
  endtask
  task automatic s_stuck(input logic [4:0] after);
    tick(1);
    rel <= after;
    stuck <= 1'b1;
    wait_rdy(1'b1, STK + 100, n);
    chk(n >= STK - 10, 1'b1);
  endtask
  task automatic s_early();
    s_stuck(5'h03);
    wait_rdy(1'b0, 7000, n);
    chk_cnt(falls, 5'h03);
    tick(1);
    stuck <= 1'b0;
    tick(40);
  endtask
  task automatic s_maxp();
    s_stuck(5'h1f);
    tick(RECOV_PULSES * 2 * RECOV_HALF_CYC + 400);
    #1;
    chk_cnt(falls, 5'h10);
    chk(ready_low, 1'b1);
    tick(1);
    stuck <= 1'b0;
    wait_rdy(1'b0, 100, n);
  endtask
  initial begin
    tick(5);
    srst <= 1'b0;
    s_idle();
    s_pass();
    s_enoff();
    s_stop();
    s_restart();
    s_early();
    s_maxp();
    tick(10);
    summarize();
  end
endmodule
